// File: rtl/sdo_check.sv
// Service data request checker with process data gating.
// Assumes a frame receiver outside hands over whole requests, a dictionary
// outside answers lookups combinationally, and the network state is an input.
`timescale 1ns/1ps
`default_nettype none
`include "sdo_check_consts.svh"

module sdo_check
  import sdo_check_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Network state
  input  wire logic [1:0]  nmt_state,
  // Request from the frame receiver
  input  wire logic        req_valid,
  input  wire sdo_frame_t  req,
  // Dictionary lookup
  output logic [15:0]      od_index,
  output logic [7:0]       od_subindex,
  input  wire od_info_t    od_info,
  // Answer toward the frame sender
  output logic             ans_valid,
  output logic             ans_abort,
  output sdo_frame_t       ans,
  output logic             wr_commit,
  // Process data, inbound and outbound
  input  wire logic        rx_pdo_valid,
  input  wire logic [2:0]  rx_pdo_slot,
  input  wire pdo_frame_t  rx_pdo,
  output logic             rx_pdo_take,
  output logic [2:0]       rx_pdo_take_slot,
  output pdo_frame_t       rx_pdo_out,
  input  wire logic        tx_pdo_valid,
  input  wire logic [2:0]  tx_pdo_slot,
  input  wire pdo_frame_t  tx_pdo,
  output logic             tx_pdo_send,
  output pdo_frame_t       tx_pdo_out,
  // Mapped length per slot, 8 slots of 7 bits
  output logic [55:0]      map_bits_flat
);

  ////////////////////////////////////////////////////////////////////////////
  // Request capture and state

  sdo_state_t  state;
  sdo_frame_t  held;
  logic        seg_active;
  logic        last_toggle;
  logic        seg_is_dl;
  wire  [6:0]  map_bits [`PDO_COUNT];

  wire [7:0] cmd_class = held.cmd & `CCS_MASK;
  wire is_init_dl = (cmd_class == `CCS_INIT_DL);
  wire is_init_ul = (cmd_class == `CCS_INIT_UL);
  wire is_dl_seg  = (cmd_class == `CCS_DL_SEG);
  wire is_ul_seg  = (cmd_class == `CCS_UL_SEG);
  wire is_abort   = (cmd_class == `CCS_ABORT);
  wire is_seg     = is_dl_seg | is_ul_seg;

  // Segments without an open transfer are treated as unknown commands
  wire seg_ok_ctx = seg_active && (seg_is_dl == is_dl_seg);
  wire cmd_bad    = !(is_init_dl | is_init_ul | is_abort | (is_seg & seg_ok_ctx));
  wire toggle_bad = is_seg && seg_ok_ctx
                    && (held.cmd[`CMD_TOGGLE_BIT] == last_toggle);

  // Expedited write byte count from n field; non-expedited lengths unchecked
  wire       expedited = held.cmd[`CMD_EXPEDITED_BIT] & held.cmd[`CMD_SIZE_BIT];
  wire [2:0] wr_bytes  = 3'h4 - {1'b0, held.cmd[3:2]};

  wire in_rx_comm = held.index >= `PDO_RX_COMM_LO && held.index <= `PDO_RX_COMM_HI;
  wire in_rx_map  = held.index >= `PDO_RX_MAP_LO  && held.index <= `PDO_RX_MAP_HI;
  wire in_tx_comm = held.index >= `PDO_TX_COMM_LO && held.index <= `PDO_TX_COMM_HI;
  wire in_tx_map  = held.index >= `PDO_TX_MAP_LO  && held.index <= `PDO_TX_MAP_HI;
  wire is_pdo_obj = in_rx_comm | in_rx_map | in_tx_comm | in_tx_map;
  wire is_map_obj = in_rx_map | in_tx_map;
  wire operational = (nmt_state == `NMT_OPERATIONAL);

  // Mapping slot: rx and tx mapping objects share the eight length trackers
  wire [2:0] slot    = held.index[2:0];
  wire       map_sub0 = is_map_obj && held.subindex == 8'h00;
  wire       map_entry = is_map_obj && held.subindex != 8'h00;
  wire [7:0] entry_bits = held.data[7:0];
  wire [7:0] new_total  = {1'b0, map_bits[slot]} + entry_bits;

  wire wr_req     = is_init_dl;
  wire val_wr     = wr_req && expedited;
  wire ro_bad     = wr_req && !od_info.writable;
  wire state_bad  = wr_req && is_pdo_obj && operational;
  wire long_bad   = val_wr && wr_bytes > od_info.size_bytes;
  wire short_bad  = val_wr && wr_bytes < od_info.size_bytes;
  wire unmappable = wr_req && map_entry && !od_info.mappable;
  wire overflow   = wr_req && map_entry && new_total > `PDO_MAX_BITS;

  // Only the declared bytes carry the value; padding bytes may hold anything.
  // A segmented initiate carries a byte count instead, so it skips these checks.
  wire [31:0] wr_mask  = (wr_bytes == 3'h1) ? 32'h000000ff :
                         (wr_bytes == 3'h2) ? 32'h0000ffff :
                         (wr_bytes == 3'h3) ? 32'h00ffffff : 32'hffffffff;
  wire [31:0] wr_value = held.data & wr_mask;
  wire errcnt_bad = val_wr && held.index == `ERR_FIELD_INDEX
                    && held.subindex == 8'h00 && wr_value != 32'h0;
  wire high_bad   = val_wr && od_info.has_max && wr_value > od_info.max_value;
  wire low_bad    = val_wr && od_info.has_min && wr_value < od_info.min_value;
  wire need_od    = is_init_dl | is_init_ul;

  // First cause wins in fixed order
  logic [31:0] next_code;
  logic        next_fail;
  always_comb begin
    next_fail = 1'b1;
    next_code = `ABORT_GENERAL;
    if (cmd_bad)                              next_code = `ABORT_UNKNOWN_CMD;
    else if (toggle_bad)                      next_code = `ABORT_TOGGLE;
    else if (need_od && !od_info.exists)      next_code = `ABORT_NO_OBJECT;
    else if (need_od && !od_info.sub_exists)  next_code = `ABORT_NO_SUBINDEX;
    else if (ro_bad)                          next_code = `ABORT_READ_ONLY;
    else if (state_bad)                       next_code = `ABORT_WRONG_STATE;
    else if (long_bad)                        next_code = `ABORT_LEN_LONG;
    else if (short_bad)                       next_code = `ABORT_LEN_SHORT;
    else if (unmappable)                      next_code = `ABORT_NOT_MAPPABLE;
    else if (overflow)                        next_code = `ABORT_MAP_OVERFLOW;
    else if (errcnt_bad || high_bad)          next_code = `ABORT_VALUE_HIGH;
    else if (low_bad)                         next_code = `ABORT_VALUE_LOW;
    else if (need_od && od_info.fault)        next_code = `ABORT_GENERAL;
    else                                      next_fail = 1'b0;
  end

  assign od_index    = held.index;
  assign od_subindex = held.subindex;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= st_idle;
      held  <= '0;
    end else begin
      case (state)
        st_idle: begin
          if (req_valid) begin
            held  <= req;
            state <= st_lookup;
          end
        end
        st_lookup: state <= st_answer;
        st_answer: state <= st_idle;
        default:   state <= st_idle;
      endcase
    end
  end

  // Answer: abort frame or a plain echo of the request command byte, index and subindex
  wire         abort_in  = is_abort && !cmd_bad;
  wire         fail_now  = (state == st_lookup) && next_fail && !abort_in;
  wire         pass_now  = (state == st_lookup) && !next_fail && !abort_in;
  wire [31:0]  code_le   = {next_code[7:0], next_code[15:8],
                            next_code[23:16], next_code[31:24]};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ans_valid <= 1'b0;
      ans_abort <= 1'b0;
      ans       <= '0;
      wr_commit <= 1'b0;
    end else begin
      ans_valid <= fail_now | pass_now;
      ans_abort <= fail_now;
      wr_commit <= pass_now && wr_req;
      if (fail_now) begin
        // Byte 4 carries the code LSB, so data is stored byte-swapped
        ans <= '{cmd: `ABORT_CMD_BYTE, index: held.index,
                 subindex: held.subindex, data: code_le};
      end else if (pass_now) begin
        ans <= '{cmd: held.cmd, index: held.index,
                 subindex: held.subindex, data: 32'h0};
      end
    end
  end

  // Segment tracking: any abort, either way, closes the transfer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seg_active  <= 1'b0;
      last_toggle <= 1'b1;
      seg_is_dl   <= 1'b0;
    end else if (state == st_lookup) begin
      if (fail_now || abort_in) begin
        seg_active  <= 1'b0;
        last_toggle <= 1'b1;
      end else if ((is_init_dl || is_init_ul) && !expedited) begin
        seg_active  <= 1'b1;
        seg_is_dl   <= is_init_dl;
        last_toggle <= 1'b1;  // first segment must carry toggle 0
      end else if (is_seg) begin
        last_toggle <= held.cmd[`CMD_TOGGLE_BIT];
        seg_active  <= !held.cmd[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mapping length trackers, one per slot

  genvar g;
  generate
    for (g = 0; g < `PDO_COUNT; g++) begin : g_map
      wire hit   = pass_now && wr_req && is_map_obj && slot == 3'(g);
      wire clear = hit && map_sub0 && held.data[7:0] == 8'h00;
      wire add   = hit && map_entry;
      map_len_track i_map_len_track (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clear   (clear),
        .add     (add),
        .total   (new_total[6:0]),
        .bits    (map_bits[g])
      );
      assign map_bits_flat[g*7 +: 7] = map_bits[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Process data gating

  // Payload and length only, no index field; both directions gate alike
  pdo_gate i_rx_pdo_gate (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .allow      (operational),
    .valid      (rx_pdo_valid),
    .slot       (rx_pdo_slot),
    .frame      (rx_pdo),
    .pass       (rx_pdo_take),
    .pass_slot  (rx_pdo_take_slot),
    .pass_frame (rx_pdo_out)
  );

  // The transmit side has no use for the slot beyond the gate
  pdo_gate i_tx_pdo_gate (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .allow      (operational),
    .valid      (tx_pdo_valid),
    .slot       (tx_pdo_slot),
    .frame      (tx_pdo),
    .pass       (tx_pdo_send),
    .pass_slot  (),
    .pass_frame (tx_pdo_out)
  );

endmodule

////////////////////////////////////////////////////////////////////////////
// Mapped length of one mapping slot, shared by its rx and tx mappings

module map_len_track
  import sdo_check_pkg::*;
#(
  parameter logic [3:0] MAX_ENTRIES = `MAP_ENTRIES
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Update from a passed mapping write
  input  wire logic       clear,
  input  wire logic       add,
  input  wire logic [6:0] total,
  // Mapped length in bits
  output logic [6:0]      bits
);
  logic [3:0] count;

  // Entries past the last one are acknowledged but not counted
  wire room = count < MAX_ENTRIES;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bits  <= '0;
      count <= '0;
    end else if (clear) begin
      bits  <= '0;
      count <= '0;
    end else if (add && room) begin
      bits  <= total;
      count <= count + 4'h1;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// Gate for one direction of process data

module pdo_gate
  import sdo_check_pkg::*;
#(
  parameter logic [3:0] MAX_BYTES = 4'h8
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Frame offered, and whether the network state lets it through
  input  wire logic       allow,
  input  wire logic       valid,
  input  wire logic [2:0] slot,
  input  wire pdo_frame_t frame,
  // Frame passed on, pulse and held copy
  output logic            pass,
  output logic [2:0]      pass_slot,
  output pdo_frame_t      pass_frame
);
  // Overlong frames are dropped whole rather than clipped
  wire ok = valid && allow && frame.len <= MAX_BYTES;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pass       <= 1'b0;
      pass_slot  <= '0;
      pass_frame <= '0;
    end else begin
      pass <= ok;
      if (ok) begin
        pass_slot  <= slot;
        pass_frame <= frame;
      end
    end
  end
endmodule

`default_nettype wire

// File: rtl/sdo_check_consts.svh
// Constants for the service data request checker: abort codes, command
// specifiers, dictionary index ranges, state encodings and limits.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SDO_CHECK_CONSTS_SVH
`define SDO_CHECK_CONSTS_SVH

`define ABORT_TOGGLE        32'h05030000
`define ABORT_UNKNOWN_CMD   32'h05040001
`define ABORT_READ_ONLY     32'h06010002
`define ABORT_NO_OBJECT     32'h06020000
`define ABORT_NOT_MAPPABLE  32'h06040041
`define ABORT_MAP_OVERFLOW  32'h06040042
`define ABORT_LEN_LONG      32'h06070012
`define ABORT_LEN_SHORT     32'h06070013
`define ABORT_NO_SUBINDEX   32'h06090011
`define ABORT_VALUE_HIGH    32'h06090031
`define ABORT_VALUE_LOW     32'h06090032
`define ABORT_GENERAL       32'h08000000
`define ABORT_WRONG_STATE   32'h08000022

`define ABORT_CMD_BYTE      8'h80
`define CCS_MASK            8'he0
`define CCS_DL_SEG          8'h00
`define CCS_INIT_DL         8'h20
`define CCS_INIT_UL         8'h40
`define CCS_UL_SEG          8'h60
`define CCS_ABORT           8'h80
`define CMD_EXPEDITED_BIT   1
`define CMD_SIZE_BIT        0
`define CMD_TOGGLE_BIT      4
`define CMD_N_LSB           2

`define PDO_RX_COMM_LO      16'h1400
`define PDO_RX_COMM_HI      16'h1407
`define PDO_RX_MAP_LO       16'h1600
`define PDO_RX_MAP_HI       16'h1607
`define PDO_TX_COMM_LO      16'h1800
`define PDO_TX_COMM_HI      16'h1807
`define PDO_TX_MAP_LO       16'h1a00
`define PDO_TX_MAP_HI       16'h1a07
`define ERR_FIELD_INDEX     16'h1003

`define PDO_COUNT           8
`define PDO_MAX_BITS        8'h40
`define MAP_ENTRIES         4'h8

`define NMT_OPERATIONAL     2'h1

`endif

// File: rtl/sdo_check_pkg.sv
// Types for the service data request checker.
// Assumes the constants header sits beside it on the include path.
`include "sdo_check_consts.svh"

package sdo_check_pkg;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] index;
    logic [7:0]  subindex;
    logic [31:0] data;
  } sdo_frame_t;

  typedef struct packed {
    logic        exists;
    logic        sub_exists;
    logic        writable;
    logic        mappable;
    logic [2:0]  size_bytes;
    logic        has_max;
    logic [31:0] max_value;
    logic        has_min;
    logic [31:0] min_value;
    logic        fault;
  } od_info_t;

  typedef struct packed {
    logic [63:0] payload;
    logic [3:0]  len;
  } pdo_frame_t;

  typedef enum logic [1:0] {
    st_idle   = 2'b00,
    st_lookup = 2'b01,
    st_answer = 2'b11
  } sdo_state_t;

endpackage

// File: verif/sdo_od_model.sv
// Small object dictionary that answers lookups the same cycle.
// Assumes the checker drives index and subindex from its held request.
`timescale 1ns/1ps
`default_nettype none

module sdo_od_model
  import sdo_check_pkg::*;
(
  // Lookup
  input  wire logic [15:0] od_index,
  input  wire logic [7:0]  od_subindex,
  output od_info_t         od_info
);
  wire sub0 = (od_subindex == 8'h00);

  // Fields: exists, sub, writable, mappable, size, max, min, fault
  always_comb begin
    od_info = '0;
    case (od_index)
      16'h2000: od_info = '{1'b1, sub0, 1'b1, 1'b1, 3'h4, 1'b1, 32'h3e8, 1'b1, 32'h0a, 1'b0};
      16'h2001: od_info = '{1'b1, sub0, 1'b0, 1'b0, 3'h1, 1'b0, 32'h0, 1'b0, 32'h0, 1'b0};
      16'h1003: od_info = '{1'b1, sub0, 1'b1, 1'b0, 3'h1, 1'b0, 32'h0, 1'b0, 32'h0, 1'b0};
      16'h1600: od_info = '{1'b1, od_subindex <= 8'h08, 1'b1, 1'b1, 3'h4, 1'b0, 32'h0, 1'b0,
                            32'h0, 1'b0};
      // Mapping whose entries the dictionary reports as not mappable
      16'h1601: od_info = '{1'b1, od_subindex <= 8'h08, 1'b1, 1'b0, 3'h4, 1'b0, 32'h0, 1'b0,
                            32'h0, 1'b0};
      // Lookup fault stands for a failure with no specific cause
      16'h2003: od_info = '{1'b1, sub0, 1'b1, 1'b0, 3'h4, 1'b0, 32'h0, 1'b0, 32'h0, 1'b1};
      default: od_info = '0;
    endcase
  end
endmodule

`default_nettype wire

// File: verif/sdo_check_monitor.sv
// Port checker for the request checker and process data gate.
// Assumes one clock and a fixed answer two cycles after each request other than an abort request, which gets none.
`timescale 1ns/1ps
`default_nettype none

module sdo_check_monitor
  import sdo_check_pkg::*;
(
  // Clock, reset, state
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [1:0] nmt_state,
  // Requests and answers
  input wire logic       req_valid,
  input wire sdo_frame_t req,
  input wire logic       ans_valid,
  input wire logic       ans_abort,
  input wire sdo_frame_t ans,
  input wire logic       wr_commit,
  // Process data
  input wire logic       rx_pdo_valid,
  input wire logic [2:0] rx_pdo_slot,
  input wire pdo_frame_t rx_pdo,
  input wire logic       rx_pdo_take,
  input wire logic [2:0] rx_pdo_take_slot,
  input wire pdo_frame_t rx_pdo_out,
  input wire logic       tx_pdo_valid,
  input wire pdo_frame_t tx_pdo,
  input wire logic       tx_pdo_send,
  input wire pdo_frame_t tx_pdo_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  ans_timing_a: assert property (ans_valid |-> $past(req_valid, 2) ##1 !ans_valid)
    else $error("answer without request two cycles before");
  abort_frame_a: assert property (ans_abort |-> ans_valid && ans.cmd == 8'h80
    && ans.index == $past(req.index, 2) && ans.subindex == $past(req.subindex, 2))
    else $error("abort frame header wrong");
  abort_code_a: assert property (ans_abort |-> ans.data != 32'h0)
    else $error("abort carries no cause");
  commit_clean_a: assert property (wr_commit |-> ans_valid && !ans_abort)
    else $error("write committed on abort");
  state_abort_a: assert property (ans_abort && ans.data == 32'h22000008
    |-> $past(nmt_state) == 2'h1) else $error("wrong state code outside operational");
  rx_gate_a: assert property (rx_pdo_take
    |-> $past(rx_pdo_valid && nmt_state == 2'h1 && rx_pdo.len <= 4'h8))
    else $error("process data taken when not allowed");
  rx_take_a: assert property (rx_pdo_valid && nmt_state == 2'h1 && rx_pdo.len <= 4'h8
    |=> rx_pdo_take && rx_pdo_take_slot == $past(rx_pdo_slot)) else $error("rx frame lost");
  rx_payload_a: assert property (rx_pdo_take |-> rx_pdo_out == $past(rx_pdo))
    else $error("rx payload altered");
  tx_gate_a: assert property (tx_pdo_valid && nmt_state != 2'h1 |=> !tx_pdo_send)
    else $error("tx sent outside operational");
  tx_payload_a: assert property (tx_pdo_send |-> tx_pdo_out == $past(tx_pdo))
    else $error("tx payload altered");
endmodule

bind sdo_check sdo_check_monitor i_sdo_check_monitor (.*);

`default_nettype wire

// File: verif/tb.sv
// Self-checking bench: request table, toggle, mapping, master abort, PDO gate.
// Assumes the dictionary model answers lookups combinationally.
`timescale 1ns/1ps
`default_nettype none
`include "sdo_check_consts.svh"

module tb
  import sdo_check_pkg::*;
;
  logic ref_clk = 0, rst = 1, req_valid = 0, rx_pdo_valid = 0, tx_pdo_valid = 0;
  logic [1:0] nmt_state = 2'h0;
  logic [2:0] rx_pdo_slot = 3'h0, tx_pdo_slot = 3'h0, rx_pdo_take_slot;
  sdo_frame_t req = '0, ans;
  pdo_frame_t rx_pdo = '0, tx_pdo = '0, rx_pdo_out, tx_pdo_out;
  od_info_t   od_info;
  logic [15:0] od_index;
  logic [7:0]  od_subindex;
  logic ans_valid, ans_abort, wr_commit, rx_pdo_take, tx_pdo_send;
  logic [55:0] map_bits_flat;
  int errors = 0, n_compared = 0;

  always #5 ref_clk = ~ref_clk;

  sdo_check i_sdo_check (.ref_clk(ref_clk), .rst(rst), .nmt_state(nmt_state),
    .req_valid(req_valid), .req(req), .od_index(od_index), .od_subindex(od_subindex),
    .od_info(od_info), .ans_valid(ans_valid), .ans_abort(ans_abort), .ans(ans),
    .wr_commit(wr_commit), .rx_pdo_valid(rx_pdo_valid), .rx_pdo_slot(rx_pdo_slot),
    .rx_pdo(rx_pdo), .rx_pdo_take(rx_pdo_take), .rx_pdo_take_slot(rx_pdo_take_slot),
    .rx_pdo_out(rx_pdo_out), .tx_pdo_valid(tx_pdo_valid), .tx_pdo_slot(tx_pdo_slot),
    .tx_pdo(tx_pdo), .tx_pdo_send(tx_pdo_send), .tx_pdo_out(tx_pdo_out),
    .map_bits_flat(map_bits_flat));
  sdo_od_model i_sdo_od_model (.od_index(od_index), .od_subindex(od_subindex),
    .od_info(od_info));

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Code zero means the request must pass
  task automatic sdo(input logic [7:0] c, input logic [15:0] i, input logic [7:0] s,
                     input logic [31:0] d, input logic [31:0] code);
    int k;
    @(negedge ref_clk);
    req_valid = 1;
    req = '{c, i, s, d};
    @(negedge ref_clk);
    req_valid = 0;
    k = 0;
    while (ans_valid !== 1'b1 && k < 4) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 4) begin
      chk(0, 1);
      complete_run();
    end else begin
      chk(ans_abort, code != 0);
      if (code != 0) begin
        chk(wr_commit, 0);
        chk(ans.data, {code[7:0], code[15:8], code[23:16], code[31:24]});
        chk({ans.cmd, ans.index, ans.subindex}, {8'h80, i, s});
      end else if (c[1:0] == 2'b11) begin
        chk(wr_commit, 1);
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_codes();
    sdo(8'he0, 16'h3000, 0, 0, `ABORT_UNKNOWN_CMD);
    sdo(8'h23, 16'h3000, 0, 0, `ABORT_NO_OBJECT);
    sdo(8'h23, 16'h2000, 8'h05, 0, `ABORT_NO_SUBINDEX);
    sdo(8'h2f, 16'h2001, 0, 0, `ABORT_READ_ONLY);
    sdo(8'h23, 16'h1003, 0, 0, `ABORT_LEN_LONG);
    sdo(8'h2f, 16'h2000, 0, 0, `ABORT_LEN_SHORT);
    sdo(8'h2f, 16'h1003, 0, 32'h5, `ABORT_VALUE_HIGH);
    sdo(8'h2f, 16'h1003, 0, 0, 0);
    sdo(8'h2f, 16'h1003, 0, 32'h100, 0);
    sdo(8'h23, 16'h2000, 0, 32'h7d0, `ABORT_VALUE_HIGH);
    sdo(8'h23, 16'h2000, 0, 32'h5, `ABORT_VALUE_LOW);
    sdo(8'h23, 16'h2000, 0, 32'h1f4, 0);
    sdo(8'h23, 16'h2003, 0, 0, `ABORT_GENERAL);
    nmt_state = 2'h1;
    sdo(8'h23, 16'h1600, 8'h01, 32'h20000008, `ABORT_WRONG_STATE);
    nmt_state = 2'h0;
    $display("test codes done");
  endtask

  task automatic t_toggle();
    sdo(8'h21, 16'h2000, 0, 32'h8, 0);
    sdo(8'h00, 16'h2000, 0, 0, 0);
    sdo(8'h00, 16'h2000, 0, 0, `ABORT_TOGGLE);
    sdo(8'h10, 16'h2000, 0, 0, `ABORT_UNKNOWN_CMD);
    $display("test toggle done");
  endtask

  // Configured in pre-operational, as the master must
  task automatic t_map();
    sdo(8'h23, 16'h1600, 0, 0, 0);
    sdo(8'h23, 16'h1600, 8'h01, 32'h20000020, 0);
    sdo(8'h23, 16'h1600, 8'h02, 32'h20000020, 0);
    sdo(8'h23, 16'h1600, 8'h03, 32'h20000008, `ABORT_MAP_OVERFLOW);
    chk(map_bits_flat[6:0], 7'h40);
    sdo(8'h23, 16'h1601, 8'h01, 32'h20000008, `ABORT_NOT_MAPPABLE);
    chk(map_bits_flat[13:7], 7'h00);
    $display("test map done");
  endtask

  task automatic t_master_abort();
    sdo(8'h21, 16'h2000, 0, 32'h8, 0);
    @(negedge ref_clk);
    req_valid = 1;
    req = '{8'h80, 16'h2000, 8'h00, 32'h0};
    @(negedge ref_clk);
    req_valid = 0;
    repeat (3) begin
      @(negedge ref_clk);
      chk(ans_valid, 0);
    end
    sdo(8'h00, 16'h2000, 0, 0, `ABORT_UNKNOWN_CMD);
    $display("test master abort done");
  endtask

  task automatic pdo(input logic tx, input logic [1:0] st, input logic [3:0] l,
                     input logic exp);
    @(negedge ref_clk);
    nmt_state = st;
    rx_pdo_valid = !tx;
    tx_pdo_valid = tx;
    rx_pdo = '{64'h0123456789abcdef, l};
    tx_pdo = rx_pdo;
    rx_pdo_slot = 3'h7;
    tx_pdo_slot = 3'h7;
    @(negedge ref_clk);
    rx_pdo_valid = 0;
    tx_pdo_valid = 0;
    chk(tx ? tx_pdo_send : rx_pdo_take, exp);
    if (exp) chk(tx ? tx_pdo_out.payload : rx_pdo_out.payload, 64'h0123456789abcdef);
    if (exp && !tx) chk(rx_pdo_take_slot, 3'h7);
  endtask

  task automatic t_pdo();
    pdo(0, 2'h1, 4'h8, 1);
    pdo(0, 2'h1, 4'h9, 0);
    pdo(0, 2'h0, 4'h8, 0);
    pdo(1, 2'h1, 4'h3, 1);
    pdo(1, 2'h2, 4'h3, 0);
    nmt_state = 2'h0;
    $display("test pdo done");
  endtask

  initial begin
    repeat (6) @(negedge ref_clk);
    rst = 0;
    t_codes();
    t_toggle();
    t_map();
    t_master_abort();
    t_pdo();
    complete_run();
  end
endmodule

`default_nettype wire
